//--- design/cpo_params.svh
// Offsets, field positions, reset values and timing figures of the camera port.
`ifndef CPO_PARAMS_SVH
`define CPO_PARAMS_SVH
`define CPO_DLY_ADDR     8'h2f
`define CPO_LEAD_ADDR    8'h5f
`define CPO_WIN_ADDR     8'h30
`define CPO_STAT_ADDR    8'h31
`define CPO_DLY_RST      8'h00
`define CPO_LEAD_RST     6'h06
`define CPO_WIN_RST      5'h02
`define CPO_DLY_EN_BIT   7
`define CPO_ROW_EN_BIT   5
`define CPO_COL_EN_BIT   4
`define CPO_WIN_EN_BIT   4
`define CPO_DEV_ADDR0    7'h3c
`define CPO_DEV_ADDR1    7'h3d
`define CPO_EXTRA        12'h004
`define CPO_LEAD_BASE    4'h8
`define CPO_T3_BASE      16'h03c0
`define CPO_WIN_BASE     4'h4
`endif

//--- design/cpo_pkg.sv
// Types shared by the camera parallel output port.
package cpo_pkg;
   typedef enum logic [4:0] {
      CPO_IDLE   = 5'h01,
      CPO_SYNC   = 5'h02,
      CPO_LEAD   = 5'h04,
      CPO_ACTIVE = 5'h08,
      CPO_DELAY  = 5'h10
   } cpo_frame_e;
   typedef enum logic [4:0] {
      CPO_BUS_IDLE = 5'h01,
      CPO_DEVADR   = 5'h02,
      CPO_REGADR   = 5'h04,
      CPO_WRDATA   = 5'h08,
      CPO_RDDATA   = 5'h10
   } cpo_bus_e;
endpackage

//--- design/cpo_buf2.sv
// Two-entry pixel buffer with valid and ready on both sides.
`timescale 1ns/1ns
module cpo_buf2
   import cpo_pkg::*;
#(
   parameter int W = 8
)(
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst_b,
   // Filling side.
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Draining side.
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   logic [W-1:0] mem_q [2];
   logic         wp_q;
   logic         rp_q;
   logic [1:0]   cnt_q;
   logic [1:0]   cnt_d;
   logic         push;
   logic         pop;

   // Ready is a flop so the source never sees a combinational path.
   assign push      = in_valid && in_ready;
   assign pop       = out_ready && out_valid;
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rp_q];
   assign cnt_d     = cnt_q + {1'b0, push} - {1'b0, pop};

   // Storage and pointers.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         cnt_q    <= 2'h0;
         in_ready <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            mem_q[wp_q] <= in_data;
            wp_q        <= ~wp_q;
         end
         if (pop)
            rp_q <= ~rp_q;
         cnt_q    <= cnt_d;
         in_ready <= (cnt_d != 2'h2);
      end
   end
endmodule

//--- design/cpo_top.sv
// Camera parallel pixel output with two-wire register port.
`timescale 1ns/1ns
`include "cpo_params.svh"
module cpo_top
   import cpo_pkg::*;
#(
   parameter int ACT_COLS = 16,
   parameter int ACT_ROWS = 8,
   parameter int H_BLANK  = 8
)(
   // System clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Pixel link clock.
   input  wire logic       pix_clk,
   // Control pins.
   input  wire logic       power_down_in,
   input  wire logic       bus_address_select,
   // Two-wire register port.
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // Pixel source, on pix_clk.
   input  wire logic       pix_in_valid,
   input  wire logic [7:0] pix_in_data,
   output logic            pix_in_ready,
   // Pixel output pins.
   output logic            pixel_clk_out,
   output logic            hsync_out,
   output logic            vsync_out,
   output logic [9:2]      pixel_data
);
   // Register bank, system domain.
   logic [7:0] dly_q;
   logic [5:0] lead_q;
   logic [4:0] win_q;
   // Pin and frame-status synchronisers, system domain.
   logic [2:0] scl_s;
   logic [2:0] sda_s;
   logic [1:0] sel_s;
   logic [1:0] pdc_s;
   logic [1:0] fa_s;
   // Two-wire slave state.
   cpo_bus_e   ph_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic       ack_q;
   logic       rw_q;
   logic       nack_q;
   logic       wr_q;
   logic       tgl_q;
   logic       scl_rise;
   logic       scl_fall;
   logic       start;
   logic       stop;
   logic [6:0] dev_addr;
   logic [7:0] rd_cur;
   // Pixel domain.
   logic       prst_s1;
   logic       pix_rst_b;
   logic [1:0] pd_s;
   logic [2:0] tgl_s;
   logic [7:0] c_dly_q;
   logic [5:0] c_lead_q;
   logic [4:0] c_win_q;
   cpo_frame_e st_q;
   logic [11:0] hcnt_q;
   logic [11:0] lines_q;
   logic [15:0] dcnt_q;
   logic [15:0] t3_q;
   logic        tick;
   logic        line_end;
   logic        act_col;
   logic [11:0] t2;
   logic [11:0] cols_tot;
   logic [11:0] rows_tot;
   logic [3:0]  lead_lines;
   logic [2:0]  win_n;
   logic        b_valid;
   logic [7:0]  b_data;
   logic        b_ready;

   // Register read decode, shared by the first and later read bytes.
   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      case (a)
         `CPO_DLY_ADDR:  rd_mux = dly_q;
         `CPO_LEAD_ADDR: rd_mux = {2'h0, lead_q};
         `CPO_WIN_ADDR:  rd_mux = {3'h0, win_q};
         `CPO_STAT_ADDR: rd_mux = {6'h00, pdc_s[1], fa_s[1]};
         default:        rd_mux = 8'h00;
      endcase
   endfunction

   // Two-flop synchronisers; the third scl/sda stage is only for edges.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         sel_s <= 2'h0;
         pdc_s <= 2'h0;
         fa_s  <= 2'h0;
      end
      else
      begin
         scl_s <= {scl_s[1:0], scl_in};
         sda_s <= {sda_s[1:0], sda_in};
         sel_s <= {sel_s[0], bus_address_select};
         pdc_s <= {pdc_s[0], power_down_in};
         fa_s  <= {fa_s[0], st_q != CPO_IDLE};
      end
   end

   assign scl_rise = scl_s[1] && !scl_s[2];
   assign scl_fall = !scl_s[1] && scl_s[2];
   assign start    = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
   assign stop     = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];
   // select picks 3CH or 3DH as the 7-bit device address
   assign dev_addr = sel_s[1] ? `CPO_DEV_ADDR1 : `CPO_DEV_ADDR0;
   // Byte that a read would send from the current pointer.
   assign rd_cur   = rd_mux(ptr_q);

   // Two-wire byte engine: bits shift in on scl rise, the pin moves on fall.
   // The pin is open drain, so sda_out stays low and only the enable moves.
   // address, then register pointer and acknowledged data bytes; a read address goes straight to read data bytes
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ph_q    <= CPO_BUS_IDLE;
         bit_q   <= 4'h0;
         sh_q    <= 8'h00;
         tx_q    <= 8'h00;
         ptr_q   <= 8'h00;
         ack_q   <= 1'b0;
         rw_q    <= 1'b0;
         nack_q  <= 1'b0;
         wr_q    <= 1'b0;
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
         dly_q   <= `CPO_DLY_RST;
         lead_q  <= `CPO_LEAD_RST;
         win_q   <= `CPO_WIN_RST;
      end
      else
      begin
         wr_q <= 1'b0;
         if (start)
         begin
            ph_q   <= CPO_DEVADR;
            bit_q  <= 4'h0;
            ack_q  <= 1'b0;
            sda_oe <= 1'b0;
         end
         else if (stop)
         begin
            ph_q   <= CPO_BUS_IDLE;
            sda_oe <= 1'b0;
         end
         else if (scl_rise && ph_q != CPO_BUS_IDLE)
         begin
            if (ack_q)
               nack_q <= sda_s[1];
            else
            begin
               sh_q  <= {sh_q[6:0], sda_s[1]};
               bit_q <= bit_q + 4'h1;
            end
         end
         else if (scl_fall && ph_q != CPO_BUS_IDLE)
         begin
            if (!ack_q && bit_q == 4'h8)
            begin
               bit_q <= 4'h0;
               ack_q <= 1'b1;
               unique case (ph_q)
                  CPO_DEVADR:
                  begin
                     rw_q   <= sh_q[0];
                     sda_oe <= (sh_q[7:1] == dev_addr);
                     if (sh_q[7:1] != dev_addr)
                        ph_q <= CPO_BUS_IDLE;
                  end
                  CPO_REGADR:
                  begin
                     ptr_q  <= sh_q;
                     sda_oe <= 1'b1;
                  end
                  CPO_WRDATA:
                  begin
                     case (ptr_q)
                        `CPO_DLY_ADDR:  dly_q  <= sh_q;
                        `CPO_LEAD_ADDR: lead_q <= sh_q[5:0];
                        `CPO_WIN_ADDR:  win_q  <= sh_q[4:0];
                        default:        ;
                     endcase
                     wr_q   <= 1'b1;
                     ptr_q  <= ptr_q + 8'h01;
                     sda_oe <= 1'b1;
                  end
                  CPO_RDDATA:
                  begin
                     ptr_q  <= ptr_q + 8'h01;
                     sda_oe <= 1'b0;
                  end
               endcase
            end
            else if (ack_q)
            begin
               ack_q <= 1'b0;
               unique case (ph_q)
                  CPO_DEVADR:
                  begin
                     ph_q   <= rw_q ? CPO_RDDATA : CPO_REGADR;
                     tx_q   <= rd_cur;
                     sda_oe <= rw_q && !rd_cur[7];
                  end
                  CPO_RDDATA:
                  begin
                     tx_q   <= rd_cur;
                     sda_oe <= !nack_q && !rd_cur[7];
                     if (nack_q)
                        ph_q <= CPO_BUS_IDLE;
                  end
                  CPO_REGADR:
                  begin
                     ph_q   <= CPO_WRDATA;
                     sda_oe <= 1'b0;
                  end
                  CPO_WRDATA:
                     sda_oe <= 1'b0;
                  default:
                     sda_oe <= 1'b0;
               endcase
            end
            else if (ph_q == CPO_RDDATA)
               sda_oe <= !tx_q[3'h7 - bit_q[2:0]];
         end
      end
   end

   // A register write toggles a flag one cycle later, once values stand.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         tgl_q <= 1'b0;
      else if (wr_q)
         tgl_q <= ~tgl_q;
   end

   // reset pin is carried into the pixel domain by two flops.
   always_ff @(posedge pix_clk)
   begin
      prst_s1   <= rst_b;
      pix_rst_b <= prst_s1;
   end

   // Pixel-domain synchronisers and configuration capture.
   // The bank is stable for many pixel clocks after a write, because a
   // two-wire byte takes far longer than the toggle takes to cross.
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_b)
      begin
         pd_s     <= 2'h0;
         tgl_s    <= 3'h0;
         c_dly_q  <= `CPO_DLY_RST;
         c_lead_q <= `CPO_LEAD_RST;
         c_win_q  <= `CPO_WIN_RST;
      end
      else
      begin
         pd_s  <= {pd_s[0], power_down_in};
         tgl_s <= {tgl_s[1:0], tgl_q};
         if (tgl_s[2] != tgl_s[1])
         begin
            c_dly_q  <= dly_q;
            c_lead_q <= lead_q;
            c_win_q  <= win_q;
         end
      end
   end

   // t2 is the full line, blanking included.
   assign cols_tot = 12'(ACT_COLS) +
                     (c_lead_q[`CPO_COL_EN_BIT] ? `CPO_EXTRA : 12'h000);
   assign t2       = cols_tot + 12'(H_BLANK);
   assign rows_tot = 12'(ACT_ROWS) +
                     (c_lead_q[`CPO_ROW_EN_BIT] ? `CPO_EXTRA : 12'h000);
   // lead of (8 - field) lines; fields above 8 give no lead.
   assign lead_lines = (c_lead_q[3:0] > `CPO_LEAD_BASE) ? 4'h0 :
                       `CPO_LEAD_BASE - c_lead_q[3:0];
   // window lines added; v_start of 4 or more adds nothing.
   assign win_n = (c_lead_q[`CPO_ROW_EN_BIT] && c_win_q[`CPO_WIN_EN_BIT]
                   && c_win_q[3:0] < `CPO_WIN_BASE) ?
                  3'(`CPO_WIN_BASE - c_win_q[3:0]) : 3'h0;
   assign tick     = pixel_clk_out;
   assign line_end = (hcnt_q == t2 - 12'h001);
   assign act_col  = (st_q == CPO_ACTIVE) && (hcnt_q < cols_tot);
   assign b_ready  = tick && act_col;

   // t3 = 960 + 2 * field, plus the window lines.
   // Held while the delay runs, so a write cannot cut under the count.
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_b)
         t3_q <= `CPO_T3_BASE;
      else if (st_q != CPO_DELAY)
         t3_q <= `CPO_T3_BASE + {8'h00, c_dly_q[6:0], 1'b0} +
                 16'(win_n * t2);
   end

   // pixel clock runs only out of power-down; data moves on its fall.
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_b || pd_s[1])
         pixel_clk_out <= 1'b0;
      else
         pixel_clk_out <= ~pixel_clk_out;
   end

   // Frame sequencer: sync line, lead lines, rows, then optional delay.
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_b || pd_s[1])
      begin
         st_q    <= CPO_IDLE;
         hcnt_q  <= 12'h000;
         lines_q <= 12'h000;
         dcnt_q  <= 16'h0000;
      end
      else if (tick)
      begin
         hcnt_q <= (line_end || st_q == CPO_DELAY || st_q == CPO_IDLE) ?
                   12'h000 : hcnt_q + 12'h001;
         unique case (st_q)
            CPO_IDLE:
               st_q <= CPO_SYNC;
            CPO_SYNC:
               if (line_end)
               begin
                  lines_q <= 12'h000;
                  st_q    <= (lead_lines == 4'h0) ? CPO_ACTIVE : CPO_LEAD;
               end
            CPO_LEAD:
               if (line_end)
               begin
                  lines_q <= lines_q + 12'h001;
                  if (lines_q == {8'h00, lead_lines} - 12'h001)
                  begin
                     lines_q <= 12'h000;
                     st_q    <= CPO_ACTIVE;
                  end
               end
            // delay state entered only when enabled
            CPO_ACTIVE:
               if (line_end)
               begin
                  lines_q <= lines_q + 12'h001;
                  if (lines_q == rows_tot - 12'h001)
                  begin
                     lines_q <= 12'h000;
                     dcnt_q  <= 16'h0000;
                     st_q    <= c_dly_q[`CPO_DLY_EN_BIT] ? CPO_DELAY
                                                           : CPO_SYNC;
                  end
               end
            CPO_DELAY:
            begin
               dcnt_q <= dcnt_q + 16'h0001;
               if (dcnt_q >= t3_q - 16'h0001)
                  st_q <= CPO_SYNC;
            end
         endcase
      end
   end

   // registered sync and pixel pins; underrun sends zero.
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_b || pd_s[1])
      begin
         vsync_out  <= 1'b0;
         hsync_out  <= 1'b0;
         pixel_data <= 8'h00;
      end
      else if (tick)
      begin
         vsync_out  <= (st_q == CPO_SYNC);
         hsync_out  <= act_col;
         pixel_data <= (act_col && b_valid) ? b_data : 8'h00;
      end
   end

   // Two-entry buffer between the pixel source and the pins.
   cpo_buf2 #(.W(8)) u_buf (
      .clk       (pix_clk),
      .rst_b     (pix_rst_b),
      .in_valid  (pix_in_valid),
      .in_data   (pix_in_data),
      .in_ready  (pix_in_ready),
      .out_valid (b_valid),
      .out_data  (b_data),
      .out_ready (b_ready)
   );

   chk_extra_rows: assert property (
      @(posedge pix_clk) disable iff (!pix_rst_b)
      st_q == CPO_ACTIVE && tick && line_end && !pd_s[1] &&
      c_lead_q[`CPO_ROW_EN_BIT] && lines_q == 12'(ACT_ROWS - 1)
      |=> st_q == CPO_ACTIVE) else $error("extra rows missing");
   chk_extra_cols: assert property (
      @(posedge pix_clk) disable iff (!pix_rst_b)
      tick && st_q == CPO_ACTIVE && !pd_s[1] &&
      c_lead_q[`CPO_COL_EN_BIT] && hcnt_q == 12'(ACT_COLS)
      |=> hsync_out) else $error("extra columns missing");
   chk_lead_count: assert property (
      @(posedge pix_clk) disable iff (!pix_rst_b)
      $past(st_q) == CPO_LEAD && st_q == CPO_ACTIVE
      |-> $past(lines_q) == {8'h00, lead_lines} - 12'h001)
      else $error("lead length wrong");
   chk_delay_off: assert property (
      @(posedge pix_clk) disable iff (!pix_rst_b)
      st_q == CPO_ACTIVE && !c_dly_q[`CPO_DLY_EN_BIT]
      |=> st_q != CPO_DELAY) else $error("delay while disabled");
   chk_delay_len: assert property (
      @(posedge pix_clk) disable iff (!pix_rst_b)
      st_q == CPO_DELAY |-> dcnt_q < t3_q) else $error("delay overrun");
   chk_win_add: assert property (
      @(posedge pix_clk) disable iff (!pix_rst_b)
      $past(win_n) == 3'h2 && $past(c_dly_q[6:0]) == 7'h00 &&
      $past(st_q) != CPO_DELAY &&
      $past(t2) == t2 |-> t3_q == `CPO_T3_BASE + {3'h0, t2, 1'b0})
      else $error("window lines not added");
   chk_pd_idle: assert property (
      @(posedge pix_clk) disable iff (!pix_rst_b)
      pd_s[1] |=> st_q == CPO_IDLE && !pixel_clk_out)
      else $error("running in power-down");
   chk_reset_pins: assert property (
      @(posedge pix_clk)
      !pix_rst_b |=> !vsync_out && !hsync_out && pixel_data == 8'h00)
      else $error("pins active in reset");
   chk_addr_ack: assert property (
      @(posedge clk) disable iff (!rst_b)
      ph_q == CPO_DEVADR && scl_fall && !ack_q && bit_q == 4'h8 &&
      !start && !stop && sh_q[7:1] == dev_addr |=> sda_oe && ack_q)
      else $error("address not acknowledged");
endmodule

//--- tb/cpo_host_model.sv
// Host-side parallel camera input that measures the frame timing it sees.
`timescale 1ns/1ns
module cpo_host_model
(
   // Pixel pins from the device.
   input wire logic       pixel_clk_out,
   input wire logic       hsync_out,
   input wire logic       vsync_out,
   input wire logic [9:2] pixel_data
);
   int         sv;
   int         wc;
   int         rows_cnt;
   int         frames;
   int         words_line;
   int         rows_frame;
   int         vs_len;
   int         lead_per;
   int         gap_per;
   int         zero_bad;
   bit         first;
   bit         vs_q;
   bit         hs_q;
   logic [7:0] q_seen[$];

   // The host samples on the rising pixel clock, where the device holds
   // every pin still; the sync edges are timed in whole pixel periods.
   // Samples the pixel pins.
   always @(posedge pixel_clk_out)
   begin
      sv = sv + 1;
      if (vsync_out && !vs_q)
      begin
         gap_per = sv;
         rows_frame = rows_cnt;
         rows_cnt = 0;
         sv = 0;
         frames++;
      end
      if (!vsync_out && vs_q)
      begin
         vs_len = sv;
         sv = 0;
         first = 1;
      end
      if (hsync_out && !hs_q)
      begin
         if (first)
            lead_per = sv;
         first = 0;
         rows_cnt++;
         wc = 0;
      end
      if (hsync_out)
      begin
         wc++;
         q_seen.push_back(pixel_data);
      end
      if (!hsync_out && hs_q)
         words_line = wc;
      if (!hsync_out && pixel_data != 8'h00)
         zero_bad++;
      vs_q = vsync_out;
      hs_q = hsync_out;
   end
endmodule

//--- tb/test_camera_parallel_output_timing.sv
// Self-checking bench for the camera parallel output port.
`timescale 1ns/1ns
`include "cpo_params.svh"
module test_camera_parallel_output_timing import cpo_pkg::*;;
   localparam int COLS  = 16;
   localparam int ROWS  = 8;
   localparam int HB    = 8;
   localparam int LIMIT = 98000;
   logic            clk;
   logic            rst_b;
   logic            pix_clk;
   logic            power_down_in;
   logic            bus_address_select;
   logic            scl;
   logic            sda_m;
   logic            pix_in_valid;
   logic [7:0]      pix_in_data;
   wire logic       sda_w;
   wire logic       sda_out;
   wire logic       sda_oe;
   wire logic       pix_in_ready;
   wire logic       pixel_clk_out;
   wire logic       hsync_out;
   wire logic       vsync_out;
   wire logic [9:2] pixel_data;
   int              n_errors;
   int              checks;
   int              cyc;
   bit              cmp_on = 1;
   logic [31:0]     rs = 32'd60;
   logic [7:0]      q_acc[$];

   // Open-drain data line with a pull-up: low if either party pulls it.
   assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);

   cpo_top #(.ACT_COLS(COLS), .ACT_ROWS(ROWS), .H_BLANK(HB)) cpo_top_inst
   (
      .clk(clk), .rst_b(rst_b), .pix_clk(pix_clk),
      .power_down_in(power_down_in),
      .bus_address_select(bus_address_select),
      .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .pix_in_valid(pix_in_valid), .pix_in_data(pix_in_data),
      .pix_in_ready(pix_in_ready), .pixel_clk_out(pixel_clk_out),
      .hsync_out(hsync_out), .vsync_out(vsync_out),
      .pixel_data(pixel_data)
   );

   cpo_host_model cpo_host_model_inst
   (
      .pixel_clk_out(pixel_clk_out), .hsync_out(hsync_out),
      .vsync_out(vsync_out), .pixel_data(pixel_data)
   );

   // Xorshift source of pixel words and configuration values.
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   task automatic complete_run();
      if (n_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Quarter of a bus bit; slow enough for the two-flop input sync.
   task automatic q();
      repeat (10) @(posedge clk);
      #1;
   endtask

   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      q();
      scl = 1;
      q();
      r = sda_w;
      q();
      scl = 0;
      q();
   endtask

   task automatic start();
      sda_m = 1;
      q();
      scl = 1;
      q();
      sda_m = 0;
      q();
      scl = 0;
      q();
   endtask

   task automatic stop();
      sda_m = 0;
      q();
      scl = 1;
      q();
      sda_m = 1;
      q();
   endtask

   task automatic xfer(input logic [7:0] b, output logic [7:0] r,
                       output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r[i]);
      bit_io(1'b1, a);
      ack = !a;
   endtask

   task automatic reg_wr(input logic [7:0] wa, ra, d, input logic exp);
      logic [7:0] r;
      logic       k;
      start();
      xfer(wa, r, k);
      chk("address ack", exp, k);
      if (k)
      begin
         xfer(ra, r, k);
         chk("pointer ack", 1, k);
         xfer(d, r, k);
         chk("data ack", 1, k);
      end
      stop();
   endtask

   task automatic reg_rd(input logic [7:0] wa, ra, exp);
      logic [7:0] r;
      logic       k;
      start();
      xfer(wa, r, k);
      xfer(ra, r, k);
      start();
      xfer(wa | 8'h01, r, k);
      xfer(8'hff, r, k);
      chk("read data", exp, r);
      stop();
   endtask

   // Waits for two more frame starts, so one whole frame, then compares timing and pixel words.
   task automatic frame_chk(input int cols, rows, lead, t3);
      int t2;
      int f;
      t2 = cols + HB;
      f = cpo_host_model_inst.frames + 2;
      while (cpo_host_model_inst.frames < f)
         @(posedge clk);
      chk("words per line", cols, cpo_host_model_inst.words_line);
      chk("rows per frame", rows, cpo_host_model_inst.rows_frame);
      chk("sync length", t2, cpo_host_model_inst.vs_len);
      chk("sync lead", lead * t2, cpo_host_model_inst.lead_per);
      chk("frame gap", (lead + rows) * t2 + t3,
          cpo_host_model_inst.gap_per);
      chk("idle pins", 0, cpo_host_model_inst.zero_bad);
      while (cpo_host_model_inst.q_seen.size() > 0 && q_acc.size() > 0)
         chk("pixel", q_acc.pop_front(),
             cpo_host_model_inst.q_seen.pop_front());
   endtask

   task automatic watch(input int n, output bit moved);
      logic v;
      v = pixel_clk_out;
      moved = 0;
      repeat (n)
      begin
         @(posedge clk);
         if (pixel_clk_out !== v)
            moved = 1;
      end
   endtask

   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   // Link clock with an odd offset so its phase is unrelated.
   initial
   begin
      pix_clk = 0;
      #7;
      forever #32 pix_clk = ~pix_clk;
   end

   // Pixel source: always offers a word, logs what the buffer takes.
   always @(posedge pix_clk)
   begin
      if (pix_in_valid && pix_in_ready && cmp_on)
         q_acc.push_back(pix_in_data);
      #1;
      pix_in_data = 8'(xs());
   end

   // Hang guard sized above the longest expected run.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         n_errors++;
         complete_run();
      end
   end

   initial
   begin
      logic [7:0] lf;
      logic [7:0] n;
      bit         mv;
      rst_b = 0;
      scl = 1;
      sda_m = 1;
      power_down_in = 0;
      bus_address_select = 0;
      pix_in_valid = 1;
      pix_in_data = 8'h00;
      repeat (20) @(posedge clk);
      #1;
      rst_b = 1;
      repeat (20) q();
      chk("buffer refuses", 0, pix_in_ready);
      reg_wr(8'h7a, `CPO_DLY_ADDR, 8'h11, 0);
      reg_rd(8'h78, `CPO_DLY_ADDR, 8'h00);
      reg_rd(8'h78, `CPO_LEAD_ADDR, 8'h06);
      bus_address_select = 1;
      reg_wr(8'h78, `CPO_DLY_ADDR, 8'h11, 0);
      reg_rd(8'h7a, `CPO_DLY_ADDR, 8'h00);
      bus_address_select = 0;
      reg_wr(8'h78, 8'h40, 8'h5a, 1);
      reg_rd(8'h78, 8'h40, 8'h00);
      frame_chk(COLS, ROWS, 2, 0);
      lf = 8'(4 + xs() % 4);
      n = 8'(xs() % 16);
      // Window start programmed to 2, the lowest allowed.
      reg_wr(8'h78, 8'h30, 8'h12, 1);
      reg_wr(8'h78, `CPO_DLY_ADDR, 8'h80 | n, 1);
      reg_wr(8'h78, `CPO_LEAD_ADDR, 8'h30 | lf, 1);
      reg_rd(8'h78, `CPO_DLY_ADDR, 8'h80 | n);
      frame_chk(COLS + 4, ROWS + 4, 8 - lf,
                960 + 2 * n + 2 * (COLS + 4 + HB));
      reg_wr(8'h78, `CPO_DLY_ADDR, 8'h05, 1);
      reg_wr(8'h78, `CPO_LEAD_ADDR, 8'h1a, 1);
      frame_chk(COLS + 4, ROWS, 0, 0);
      cmp_on = 0;
      q_acc.delete();
      cpo_host_model_inst.q_seen.delete();
      // Clock keeps running; power-down held far beyond 100 ns.
      power_down_in = 1;
      repeat (40) @(posedge clk);
      watch(60, mv);
      chk("clock stopped", 0, mv);
      chk("pins idle", 0, {hsync_out, vsync_out, pixel_data});
      #1;
      power_down_in = 0;
      watch(100, mv);
      chk("clock resumes", 1, mv);
      #1;
      rst_b = 0;
      repeat (30) @(posedge clk);
      #1;
      chk("reset pins", 0, {pix_in_ready, sda_oe, hsync_out,
                            vsync_out, pixel_data});
      rst_b = 1;
      // Bus use waits after power-down; the wait is scaled down here.
      repeat (4) q();
      reg_rd(8'h78, `CPO_LEAD_ADDR, 8'h06);
      complete_run();
   end
endmodule
